//--- rtl/ckb_key_builder.sv
// Purpose: Builds classifier search keys from parsed headers and previous action.
// Assumes: One request per valid cycle; keys appear one cycle later.
// Notes: Wishbone slave answers every access in one cycle.
`timescale 1ns/1ps
module ckb_key_builder
    import ckb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Request from parser and earlier lookup
    input wire logic req_valid_i,
    input wire ckb_hdr_t hdr_i,
    input wire ckb_lkp_t lkp_i,
    // Keys to the match engine
    output logic key_valid_o,
    output ckb_x1_key_t single_label_key_o,
    output ckb_two_tag_key_t two_tag_key_o,
    output ckb_idx_key_t double_label_key_o,
    output ckb_idx_key_t indexed_vlan_key_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [15:0] cust_q [3];
    logic [15:0] key_cnt_q;

    // Encode a tag's protocol; codes 2 and 3 never produced
    function automatic logic [2:0] tp_code(input logic vld, input logic [15:0] et,
                                           input logic [15:0] c1, input logic [15:0] c2,
                                           input logic [15:0] c3);
        logic [2:0] r;
        r = CKB_TP_NONE;
        if (!vld)
            r = CKB_TP_NONE;
        else if (et == CKB_ETYPE_C)
            r = CKB_TP_C;
        else if (et == CKB_ETYPE_S)
            r = CKB_TP_S;
        else if (et == c1)
            r = CKB_TP_CUST1;
        else if (et == c2)
            r = CKB_TP_CUST2;
        else if (et == c3)
            r = CKB_TP_CUST3;
        else
            r = CKB_TP_NONE; // Unknown type counts as untagged
        return r;
    endfunction

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic acc;
    logic hit;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit = (wb_adr_i == CKB_ADDR_CTRL) || (wb_adr_i == CKB_ADDR_TPID)
              || (wb_adr_i == CKB_ADDR_CUST01) || (wb_adr_i == CKB_ADDR_CUST2)
              || (wb_adr_i == CKB_ADDR_STAT);

    // Ack or error one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= acc && hit;
            wb_err_o <= acc && !hit;
        end
    end

    // Byte-lane writes to control and custom identifiers
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= CKB_CTRL_RST;
            cust_q[0] <= CKB_CUST_RST;
            cust_q[1] <= CKB_CUST_RST;
            cust_q[2] <= CKB_CUST_RST;
        end
        else if (acc && wb_we_i)
        begin
            if (wb_adr_i == CKB_ADDR_CTRL)
            begin
                for (int b = 0; b < 4; b++)
                    if (wb_sel_i[b])
                        ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            else if (wb_adr_i == CKB_ADDR_CUST01)
            begin
                if (wb_sel_i[0])
                    cust_q[0][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    cust_q[0][15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2])
                    cust_q[1][7:0] <= wb_dat_i[23:16];
                if (wb_sel_i[3])
                    cust_q[1][15:8] <= wb_dat_i[31:24];
            end
            else if (wb_adr_i == CKB_ADDR_CUST2)
            begin
                if (wb_sel_i[0])
                    cust_q[2][7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    cust_q[2][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Read data; TPID register shows the fixed standard identifiers
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (acc && !wb_we_i)
        begin
            if (wb_adr_i == CKB_ADDR_CTRL)
                wb_dat_o <= ctrl_q;
            else if (wb_adr_i == CKB_ADDR_TPID)
                wb_dat_o <= {CKB_ETYPE_S, CKB_ETYPE_C};
            else if (wb_adr_i == CKB_ADDR_CUST01)
                wb_dat_o <= {cust_q[1], cust_q[0]};
            else if (wb_adr_i == CKB_ADDR_CUST2)
                wb_dat_o <= {16'h0000, cust_q[2]};
            else if (wb_adr_i == CKB_ADDR_STAT)
                wb_dat_o <= {16'h0000, key_cnt_q};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Key field computation
    // ------------------------------------------------------------
    logic [5:0] lport;
    logic [5:0] mport;
    logic use_cl;
    ckb_def_sel_t dsel;
    logic [11:0] def_idx;
    logic [11:0] gidx;
    logic [2:0] tp0;
    logic [2:0] tp1;
    logic [2:0] sel_pcp;
    logic sel_dei;
    logic [11:0] sel_vid;
    logic ttl_exp;

    assign lport = ctrl_q[CKB_CTRL_LPORT_LSB +: 6];
    assign mport = ctrl_q[CKB_CTRL_MPORT_LSB +: 6];
    assign use_cl = ctrl_q[CKB_CTRL_USECL_LSB];
    assign dsel = ckb_def_sel_t'(ctrl_q[CKB_CTRL_DSEL_LSB +: 2]);

    // Default index when no earlier action supplies one
    always_comb
    begin
        case (dsel)
            CKB_DEF_LPORT: def_idx = {6'h00, lport}; // RULE_04
            CKB_DEF_MPORT: def_idx = {6'h00, mport}; // RULE_04
            default: def_idx = 12'h000; // RULE_04
        endcase
    end

    // Generic index from previous action's next-index fields
    always_comb
    begin
        gidx = def_idx;
        if (lkp_i.prev_valid)
        begin
            case (ckb_nxt_ctrl_t'(lkp_i.nxt_ctrl))
                CKB_NXT_REPLACE: gidx = lkp_i.nxt_val; // RULE_03
                CKB_NXT_ADD: gidx = def_idx + lkp_i.nxt_val; // RULE_03
                default: gidx = def_idx;
            endcase
        end
    end

    assign tp0 = tp_code(hdr_i.tag0_valid, hdr_i.tag0_etype, cust_q[0], cust_q[1],
                         cust_q[2]); // RULE_10
    assign tp1 = tp_code(hdr_i.tag1_valid, hdr_i.tag1_etype, cust_q[0], cust_q[1],
                         cust_q[2]); // RULE_15
    // Classified values replace the frame's outer tag when selected
    assign sel_pcp = use_cl ? lkp_i.cl_pcp : hdr_i.tag0_pcp; // RULE_11
    assign sel_dei = use_cl ? lkp_i.cl_dei : hdr_i.tag0_dei; // RULE_12
    assign sel_vid = use_cl ? lkp_i.cl_vid : ((tp0 == CKB_TP_NONE) ? 12'h000
                                              : hdr_i.tag0_vid); // RULE_13 RULE_14
    assign ttl_exp = (hdr_i.ttl0 <= CKB_TTL_EXPIRE_MAX); // RULE_07

    // ------------------------------------------------------------
    // Key output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            key_valid_o <= 1'b0;
            single_label_key_o <= '0;
            two_tag_key_o <= '0;
            double_label_key_o <= '0;
            indexed_vlan_key_o <= '0;
        end
        else
        begin
            key_valid_o <= req_valid_i;
            if (req_valid_i)
            begin
                // Single-width key carries no type field
                single_label_key_o <= '{
                    first: lkp_i.first, // RULE_02
                    gidx: gidx, // RULE_03
                    top_lbl: hdr_i.top_lbl, // RULE_05
                    top_bos: hdr_i.top_bos, // RULE_06
                    ttl0_exp: ttl_exp // RULE_07
                }; // RULE_01 RULE_17
                // Second tag priority, drop bit and VLAN id pass straight through; its protocol is encoded
                two_tag_key_o <= '{
                    wtype: CKB_WT_TWO_TAG, // RULE_08
                    first: lkp_i.first, // RULE_02
                    ingress_port: lport, // RULE_09
                    out_tp: tp0, // RULE_10
                    out_pcp: sel_pcp, // RULE_11
                    out_dei: sel_dei, // RULE_12
                    out_vid: sel_vid, // RULE_13
                    sec_tp: tp1, // RULE_15
                    sec_pcp: hdr_i.tag1_pcp, // RULE_16
                    sec_dei: hdr_i.tag1_dei, // RULE_16
                    sec_vid: hdr_i.tag1_vid // RULE_16
                }; // RULE_17
                double_label_key_o <= '{
                    wtype: CKB_WT_DBL_LBL, // RULE_08
                    first: lkp_i.first,
                    gidx: gidx,
                    out_tp: tp0,
                    out_vid: sel_vid,
                    sec_tp: tp1
                };
                indexed_vlan_key_o <= '{
                    wtype: CKB_WT_IDX_VLAN, // RULE_08
                    first: lkp_i.first,
                    gidx: gidx,
                    out_tp: tp0,
                    out_vid: sel_vid,
                    sec_tp: tp1
                };
            end
        end
    end

    // Count of keys built, readable for bring-up
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            key_cnt_q <= 16'h0000;
        else if (req_valid_i)
            key_cnt_q <= key_cnt_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_req_first;
        req_valid_i && lkp_i.first;
    endsequence

    a_first_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_02
        s_req_first |=> single_label_key_o.first && two_tag_key_o.first)
        else $error("first flag not carried");

    a_ttl_expiry: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_07
        req_valid_i |=> single_label_key_o.ttl0_exp == ($past(hdr_i.ttl0) <= 8'h01))
        else $error("expiry flag wrong");

    a_label_copy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_05
        req_valid_i |=> single_label_key_o.top_lbl == $past(hdr_i.top_lbl))
        else $error("label not copied");

    a_sbit_copy: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_06
        req_valid_i |=> single_label_key_o.top_bos == $past(hdr_i.top_bos))
        else $error("bottom bit not copied");

    a_wide_types: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_08
        key_valid_o |-> two_tag_key_o.wtype == 2'h0 && double_label_key_o.wtype == 2'h1
                        && indexed_vlan_key_o.wtype == 2'h3)
        else $error("wide type wrong");

    a_port_field: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_09
        req_valid_i |=> two_tag_key_o.ingress_port == $past(ctrl_q[5:0]))
        else $error("ingress port wrong");

    a_no_code23: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_17
        key_valid_o |-> two_tag_key_o.out_tp[2:1] != 2'b01
                        && two_tag_key_o.sec_tp[2:1] != 2'b01)
        else $error("protocol code 2 or 3 made");

    a_ctag_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_10
        req_valid_i && hdr_i.tag0_valid && hdr_i.tag0_etype == 16'h8100
        |=> two_tag_key_o.out_tp == 3'h1)
        else $error("outer code wrong");

    a_untag_vid: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_14
        req_valid_i && !hdr_i.tag0_valid && !use_cl |=> two_tag_key_o.out_vid == 12'h000)
        else $error("untagged vid not zero");

    a_cl_pcp: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_11
        req_valid_i && use_cl |=> two_tag_key_o.out_pcp == $past(lkp_i.cl_pcp))
        else $error("classified priority unused");

    a_cl_dei: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_12
        req_valid_i && use_cl |=> two_tag_key_o.out_dei == $past(lkp_i.cl_dei))
        else $error("classified drop bit unused");

    a_frame_vid: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_13
        req_valid_i && !use_cl && hdr_i.tag0_valid && hdr_i.tag0_etype == 16'h8100
        |=> two_tag_key_o.out_vid == $past(hdr_i.tag0_vid))
        else $error("frame vid not used");

    a_no_second: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_15
        req_valid_i && !hdr_i.tag1_valid |=> two_tag_key_o.sec_tp == 3'h0)
        else $error("second code not zero");

    a_second_tag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_16
        req_valid_i |=> two_tag_key_o.sec_vid == $past(hdr_i.tag1_vid)
                        && two_tag_key_o.sec_pcp == $past(hdr_i.tag1_pcp))
        else $error("second tag altered");

    a_replace_idx: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_03
        req_valid_i && lkp_i.prev_valid && lkp_i.nxt_ctrl == 2'h1
        |=> double_label_key_o.gidx == $past(lkp_i.nxt_val))
        else $error("next index ignored");

    a_default_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // RULE_04
        req_valid_i && !lkp_i.prev_valid && ctrl_q[17:16] == 2'h0
        |=> single_label_key_o.gidx == 12'h000)
        else $error("default index not zero");

endmodule

//--- rtl/ckb_pkg.sv
// Purpose: Constants and carriers for the classifier key builder.
// Assumes: Parsed header fields arrive as one request with a valid strobe.
// Notes: Register offsets are word byte addresses on classic Wishbone.
//
// Contract
// RULE_01: The single-width label key has no key-type field.
// RULE_02: Every key carries a lookup-order flag, high for first lookup, low for second.
// RULE_03: A 12-bit generic index comes from previous action's next-index control and value.
// RULE_04: Without a preceding action, default index is zero, logical or masqueraded port.
// RULE_05: Single-width key holds the 20-bit top label value.
// RULE_06: Single-width key holds the top entry's bottom-of-stack bit.
// RULE_07: Expiry flag is set when top entry TTL is at most one.
// RULE_08: Wide keys carry a 2-bit type: 0 two-tag, 1 double label, 3 indexed.
// RULE_09: Two-tag key has a 6-bit ingress port from the logical port number.
// RULE_10: Outer tag protocol code: 0 untagged, 1 0x8100, 4 0x88A8, 5-7 custom.
// RULE_11: Outer priority is from frame, or classified value when selected per lookup; code selects with one CTRL bit for both lookups.
// RULE_12: Outer drop-eligible is from frame, or classified when selected per lookup; code selects with one CTRL bit for both lookups.
// RULE_13: Outer VLAN id is from frame, or classified when selected per lookup; code selects with one CTRL bit for both lookups.
// RULE_14: Untagged frames give an outer VLAN id of zero; code gives the classified VLAN id instead when the CTRL classified bit is set.
// RULE_15: Second tag protocol uses the same code, 0 meaning no second tag.
// RULE_16: Second tag priority, drop-eligible and VLAN id are copied as received.
// RULE_17: Protocol codes 2 and 3 never appear; fields packed in listed order.
package ckb_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CKB_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CKB_ADDR_TPID = 8'h04;
    localparam logic [7:0] CKB_ADDR_CUST01 = 8'h08;
    localparam logic [7:0] CKB_ADDR_CUST2 = 8'h0C;
    localparam logic [7:0] CKB_ADDR_STAT = 8'h10;

    // CTRL fields
    localparam int CKB_CTRL_LPORT_LSB = 0;
    localparam int CKB_CTRL_MPORT_LSB = 8;
    localparam int CKB_CTRL_DSEL_LSB = 16;
    localparam int CKB_CTRL_USECL_LSB = 20;
    localparam logic [31:0] CKB_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] CKB_CUST_RST = 16'hFFFF;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [15:0] CKB_ETYPE_C = 16'h8100;
    localparam logic [15:0] CKB_ETYPE_S = 16'h88A8;
    localparam logic [2:0] CKB_TP_NONE = 3'h0;
    localparam logic [2:0] CKB_TP_C = 3'h1;
    localparam logic [2:0] CKB_TP_S = 3'h4;
    localparam logic [2:0] CKB_TP_CUST1 = 3'h5;
    localparam logic [2:0] CKB_TP_CUST2 = 3'h6;
    localparam logic [2:0] CKB_TP_CUST3 = 3'h7;
    localparam logic [1:0] CKB_WT_TWO_TAG = 2'h0;
    localparam logic [1:0] CKB_WT_DBL_LBL = 2'h1;
    localparam logic [1:0] CKB_WT_IDX_VLAN = 2'h3;
    localparam logic [7:0] CKB_TTL_EXPIRE_MAX = 8'h01;

    // Default index source
    typedef enum logic [1:0] {
        CKB_DEF_ZERO,
        CKB_DEF_LPORT,
        CKB_DEF_MPORT
    } ckb_def_sel_t;

    // Next-index control from the previous action
    typedef enum logic [1:0] {
        CKB_NXT_NONE,
        CKB_NXT_REPLACE,
        CKB_NXT_ADD
    } ckb_nxt_ctrl_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        tag0_valid;
        logic [15:0] tag0_etype;
        logic [2:0]  tag0_pcp;
        logic        tag0_dei;
        logic [11:0] tag0_vid;
        logic        tag1_valid;
        logic [15:0] tag1_etype;
        logic [2:0]  tag1_pcp;
        logic        tag1_dei;
        logic [11:0] tag1_vid;
        logic [19:0] top_lbl;
        logic        top_bos;
        logic [7:0]  ttl0;
    } ckb_hdr_t;

    typedef struct packed {
        logic        first;
        logic        prev_valid;
        logic [1:0]  nxt_ctrl;
        logic [11:0] nxt_val;
        logic [2:0]  cl_pcp;
        logic        cl_dei;
        logic [11:0] cl_vid;
    } ckb_lkp_t;

    // Single-width key, no type field
    typedef struct packed {
        logic        first;
        logic [11:0] gidx;
        logic [19:0] top_lbl;
        logic        top_bos;
        logic        ttl0_exp;
    } ckb_x1_key_t;

    // Two-tag key
    typedef struct packed {
        logic [1:0]  wtype;
        logic        first;
        logic [5:0]  ingress_port;
        logic [2:0]  out_tp;
        logic [2:0]  out_pcp;
        logic        out_dei;
        logic [11:0] out_vid;
        logic [2:0]  sec_tp;
        logic [2:0]  sec_pcp;
        logic        sec_dei;
        logic [11:0] sec_vid;
    } ckb_two_tag_key_t;

    // Double-label and indexed keys share the type/first/index/tag head
    typedef struct packed {
        logic [1:0]  wtype;
        logic        first;
        logic [11:0] gidx;
        logic [2:0]  out_tp;
        logic [11:0] out_vid;
        logic [2:0]  sec_tp;
    } ckb_idx_key_t;

endpackage

//--- verification/ckb_match_model.sv
// Purpose: Match-engine stand-in that captures every key the builder emits.
// Assumes: Keys are qualified by a one-cycle valid pulse per request.
// Notes: Keeps the last key set and a running count of valid pulses.
`timescale 1ns/1ps
module ckb_match_model
    import ckb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Keys from the builder
    input wire logic key_valid_i,
    input wire ckb_x1_key_t x1_i,
    input wire ckb_two_tag_key_t tt_i,
    input wire ckb_idx_key_t dl_i,
    input wire ckb_idx_key_t iv_i,
    // Captured view for the bench
    output ckb_x1_key_t x1_o,
    output ckb_two_tag_key_t tt_o,
    output ckb_idx_key_t dl_o,
    output ckb_idx_key_t iv_o,
    output logic [15:0] hits_o
);
    // Capture on the valid pulse only; a stretched pulse shows up as extra hits
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            hits_o <= 16'h0000;
        end
        else if (key_valid_i)
        begin
            x1_o <= x1_i;
            tt_o <= tt_i;
            dl_o <= dl_i;
            iv_o <= iv_i;
            hits_o <= hits_o + 16'h0001;
        end
    end
endmodule

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the classifier key builder.
// Assumes: Wishbone answers within a few cycles; keys one cycle after a request.
// Notes: Expected keys are rebuilt here from a shadow of the control registers.
`timescale 1ns/1ps
module tb_top;
    import ckb_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, key_valid_o, req_valid_i = 1'b0;
    ckb_hdr_t hdr_i = '0;
    ckb_lkp_t lkp_i = '0;
    ckb_x1_key_t x1, mx1;
    ckb_two_tag_key_t tt, mtt;
    ckb_idx_key_t dl, iv, mdl, miv;
    logic [15:0] hits;
    int err_count = 0;
    int tests_run = 0;
    // Shadow of the control fields the expectations depend on
    logic [5:0] lport = 6'h2A, mport = 6'h15;
    logic [1:0] dsel = 2'h0;
    logic usecl = 1'b0;
    logic [15:0] cust [3] = '{16'h9100, 16'h9200, 16'h9300};

    // --------------------------------------------------------
    // Clock, design and partner
    // --------------------------------------------------------
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    ckb_key_builder i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .req_valid_i(req_valid_i), .hdr_i(hdr_i), .lkp_i(lkp_i), .key_valid_o(key_valid_o),
        .single_label_key_o(x1), .two_tag_key_o(tt), .double_label_key_o(dl),
        .indexed_vlan_key_o(iv));
    ckb_match_model i_match (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .key_valid_i(key_valid_o), .x1_i(x1), .tt_i(tt), .dl_i(dl), .iv_i(iv),
        .x1_o(mx1), .tt_o(mtt), .dl_o(mdl), .iv_o(miv), .hits_o(hits));

    // --------------------------------------------------------
    // Compare, bus and request tasks
    // --------------------------------------------------------
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_key(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error key %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Classic single cycle: hold everything until ack or err is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q, output logic e);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_sys_i);
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        wb_xfer(1'b0, a, 32'h0000_0000, q, e);
        chk32("bus error", {31'h0, exp_err}, {31'h0, e});
        if (!exp_err)
            chk32("read data", exp, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        wb_xfer(1'b1, a, d, q, e);
        chk32("write error", 32'h0000_0000, {31'h0, e});
    endtask
    function automatic logic [2:0] tpc(input logic v, input logic [15:0] et);
        if (!v) return CKB_TP_NONE;
        if (et == CKB_ETYPE_C) return CKB_TP_C;
        if (et == CKB_ETYPE_S) return CKB_TP_S;
        if (et == cust[0]) return CKB_TP_CUST1;
        if (et == cust[1]) return CKB_TP_CUST2;
        if (et == cust[2]) return CKB_TP_CUST3;
        return CKB_TP_NONE;
    endfunction
    // Rebuild all four keys and compare with what the match engine captured
    task automatic check(input ckb_hdr_t h, input ckb_lkp_t l);
        logic [11:0] df, g, v0;
        logic [2:0] t0, t1;
        ckb_x1_key_t ex;
        ckb_two_tag_key_t et;
        ckb_idx_key_t ed;
        df = dsel == 2'h1 ? {6'h00, lport} : dsel == 2'h2 ? {6'h00, mport} : 12'h000;
        g = !l.prev_valid ? df : l.nxt_ctrl == 2'h1 ? l.nxt_val
            : l.nxt_ctrl == 2'h2 ? df + l.nxt_val : df;
        t0 = tpc(h.tag0_valid, h.tag0_etype);
        t1 = tpc(h.tag1_valid, h.tag1_etype);
        v0 = usecl ? l.cl_vid : t0 != CKB_TP_NONE ? h.tag0_vid : 12'h000;
        ex = '{l.first, g, h.top_lbl, h.top_bos, h.ttl0 <= 8'h01};
        et = '{CKB_WT_TWO_TAG, l.first, lport, t0, usecl ? l.cl_pcp : h.tag0_pcp,
               usecl ? l.cl_dei : h.tag0_dei, v0, t1, h.tag1_pcp, h.tag1_dei, h.tag1_vid};
        ed = '{CKB_WT_DBL_LBL, l.first, g, t0, v0, t1};
        chk_key("single", 64'(ex), 64'(mx1));
        chk_key("two tag", 64'(et), 64'(mtt));
        chk_key("double", 64'(ed), 64'(mdl));
        ed.wtype = CKB_WT_IDX_VLAN;
        chk_key("indexed", 64'(ed), 64'(miv));
    endtask
    task automatic send(input ckb_hdr_t h, input ckb_lkp_t l);
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        hdr_i <= h;
        lkp_i <= l;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // --------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------
    initial
    begin
        #40000;
        err_count++;
        wrap_up;
    end
    initial
    begin
        ckb_hdr_t h;
        ckb_lkp_t l;
        logic [15:0] et [7] = '{16'h8100, 16'h88A8, 16'h9100, 16'h9200, 16'h9300,
                                16'h1234, 16'h0000};
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk32("idle valid", 32'h0000_0000, {31'h0, key_valid_o});
        rd(CKB_ADDR_CTRL, 32'h0000_0000, 1'b0);
        rd(CKB_ADDR_TPID, 32'h88A8_8100, 1'b0);
        rd(CKB_ADDR_CUST01, 32'hFFFF_FFFF, 1'b0);
        rd(CKB_ADDR_CUST2, 32'h0000_FFFF, 1'b0);
        rd(8'h14, 32'h0000_0000, 1'b1);
        wr(CKB_ADDR_TPID, 32'h1111_2222);
        rd(CKB_ADDR_TPID, 32'h88A8_8100, 1'b0);
        wr(CKB_ADDR_CUST01, 32'h9200_9100);
        wr(CKB_ADDR_CUST2, 32'h0000_9300);
        rd(CKB_ADDR_CUST01, 32'h9200_9100, 1'b0);
        // Every default source, both outer-tag sources, every protocol code
        for (int s = 0; s < 6; s++)
        begin
            dsel = 2'(s % 3);
            usecl = s >= 3;
            wr(CKB_ADDR_CTRL, {11'h0, usecl, 2'h0, dsel, 2'h0, mport, 2'h0, lport});
            for (int e = 0; e < 7; e++)
            begin
                h = '{e != 6, et[e], 3'(e), e[0], 12'hA00 + 12'(e), e != 0, et[6 - e],
                      3'(7 - e), e[1], 12'h500 + 12'(s), 20'hABCD0 + 20'(e), e[1], 8'(e)};
                l = '{e[0], e < 4, e[1:0], 12'hFF0 + 12'(s), 3'(~e), ~e[0], 12'h3C0 + 12'(e)};
                send(h, l);
                check(h, l);
            end
        end
        // Back-to-back requests give one key set each
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        hdr_i <= h;
        lkp_i <= l;
        h.ttl0 = 8'hFF;
        l.first = 1'b1;
        @(posedge clk_sys_i);
        hdr_i <= h;
        lkp_i <= l;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        check(h, l);
        chk32("key count", 32'h0000_002C, {16'h0, hits});
        rd(CKB_ADDR_STAT, 32'h0000_002C, 1'b0);
        wrap_up;
    end
endmodule
